/* src/port_pullup_direction_regs.sv */
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

module port_pullup_direction_regs #(
   parameter int WIDTH = `PORT_WIDTH,
   parameter int PORTS = `PULLUP_PORT_COUNT
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [1:0] mode_pins,
   input wire port_regs_pkg::bus_addr_t bus_addr,
   input wire port_regs_pkg::port_byte_t bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output port_regs_pkg::port_byte_t bus_rdata,
   output logic [WIDTH*PORTS-1:0] pullup_on,
   output logic [WIDTH-1:0] port1_out,
   output logic [WIDTH-1:0] port1_oe
);
   import port_regs_pkg::*;

   // ==========================================================
   // Elaboration checks
   // The address map has exactly three pull-up bytes of eight bits
   if (WIDTH != `PORT_WIDTH || PORTS != `PULLUP_PORT_COUNT) begin : g_bad_params
      $error("port_pullup_direction_regs: WIDTH must be 8 and PORTS 3");
   end

   // ==========================================================
   // Decode helper, used by every register select
   function automatic logic addr_hit(input bus_addr_t addr, input bus_addr_t target);
      addr_hit = (addr == target);
   endfunction

   // ==========================================================
   // Mode pin synchroniser
   // Mode pins come from outside, so two flops before any logic
   logic [1:0] mode_meta_reg; // First stage, read only by second
   logic [1:0] mode_sync_reg; // Second stage
   logic [1:0] mode_meta_next;
   logic [1:0] mode_sync_next;

   always_comb begin
      mode_meta_next = mode_pins;
      mode_sync_next = mode_meta_reg;
   end

   // No reset: these only carry a level across
   always_ff @(posedge sys_clk) begin
      mode_meta_reg <= mode_meta_next;
      mode_sync_reg <= mode_sync_next;
   end

   // ==========================================================
   // Mode latch
   // Mode is caught while reset is held; pins moving later are ignored,
   // which keeps the direction lock stable during operation
   op_mode_t mode_reg; // Latched operating mode
   op_mode_t mode_next;
   op_mode_t mode_now; // Mode decoded from synchronised pins

   always_comb begin
      mode_now = (mode_sync_reg == `MODE_CODE_1) ? OP_MODE_SINGLE : OP_MODE_EXPANDED;
      mode_next = sys_rst ? mode_now : mode_reg;
   end

   always_ff @(posedge sys_clk) begin
      mode_reg <= mode_next;
   end

   // ==========================================================
   // Register selects
   logic [PORTS-1:0] pullup_wr; // Write to each pull-up byte
   logic dir_wr; // Write to direction byte
   logic data_wr; // Write to data byte

   always_comb begin
      dir_wr = bus_wr && addr_hit(bus_addr, `ADDR_PORT1_DIRECTION);
      data_wr = bus_wr && addr_hit(bus_addr, `ADDR_PORT1_OUTPUT_VALUE);
   end

   // ==========================================================
   // Pull-up control bytes, consecutive addresses
   logic [WIDTH-1:0] pullup_val [PORTS]; // Stored pull-up bytes

   for (genvar p = 0; p < PORTS; p++) begin : g_pullup
      // Address is base plus port index
      assign pullup_wr[p] = bus_wr && addr_hit(bus_addr, `ADDR_PORT1_PULLUP_ENABLE + 16'(p));

      port_byte_reg #(.WIDTH(WIDTH)) u_pullup (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .rst_value(`RST_PULLUP),
         .force_en(1'b0),
         .force_value(`RST_PULLUP),
         .wr_en(pullup_wr[p]),
         .wr_data(bus_wdata),
         .value(pullup_val[p])
      );

      // Bit n of the byte is pin n; the flop output goes straight out
      assign pullup_on[p*WIDTH +: WIDTH] = pullup_val[p];
   end

   // ==========================================================
   // Port 1 direction
   logic [WIDTH-1:0] dir_val; // Stored direction byte
   logic dir_lock; // Mode 1 pins the byte at all ones
   logic [WIDTH-1:0] dir_rst_value; // Reset value from current mode

   always_comb begin
      // During reset the latch is still loading, so use the live mode
      dir_rst_value = (mode_now == OP_MODE_SINGLE) ? `RST_DIRECTION_MODE1 : `RST_DIRECTION_MODE23;
      dir_lock = !sys_rst && (mode_reg == OP_MODE_SINGLE);
   end

   port_byte_reg #(.WIDTH(WIDTH)) u_direction (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rst_value(dir_rst_value),
      .force_en(dir_lock),
      .force_value(`RST_DIRECTION_MODE1),
      .wr_en(dir_wr),
      .wr_data(bus_wdata),
      .value(dir_val)
   );

   // Direction bits are the enables: 1 drives, 0 releases the pin
   assign port1_oe = dir_val;

   // ==========================================================
   // Port 1 data
   logic [WIDTH-1:0] data_val; // Stored data byte

   port_byte_reg #(.WIDTH(WIDTH)) u_output_value (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rst_value(`RST_OUTPUT_VALUE),
      .force_en(1'b0),
      .force_value(`RST_OUTPUT_VALUE),
      .wr_en(data_wr),
      .wr_data(bus_wdata),
      .value(data_val)
   );

   // Only meaningful where the enable is high
   assign port1_out = data_val;

   // ==========================================================
   // Read data path, one cycle after the strobe
   port_byte_t rdata_reg; // Registered read data
   port_byte_t rdata_next;

   always_comb begin
      rdata_next = `READ_UNMAPPED;
      if (bus_rd) begin
         // Unmapped addresses answer zero, never stall
         for (int p = 0; p < PORTS; p++) begin
            if (addr_hit(bus_addr, `ADDR_PORT1_PULLUP_ENABLE + 16'(p))) begin
               rdata_next = pullup_val[p];
            end
         end
         if (addr_hit(bus_addr, `ADDR_PORT1_DIRECTION)) begin
            // Write-only: the stored byte is not visible
            rdata_next = `READ_WRITE_ONLY;
         end
         if (addr_hit(bus_addr, `ADDR_PORT1_OUTPUT_VALUE)) begin
            rdata_next = data_val;
         end
      end
   end

   // Data stands one cycle only, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_reg <= `READ_UNMAPPED;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign bus_rdata = rdata_reg;

   // ==========================================================
   // Assertions
   a_pullup_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pullup_wr[1] |=> pullup_on[2*WIDTH-1:WIDTH] == $past(bus_wdata))
      else $error("port 2 pull-up byte did not take the write");

   // Reset level then look one cycle on, so the first tick has no history to lean on
   a_pullup_reset_clear: assert property (@(posedge sys_clk)
      sys_rst |=> pullup_on == '0)
      else $error("pull-up bits not clear after reset");

   // Write at the start of the match, held two quiet cycles later
   a_pullup_follows_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (pullup_wr[0] && !sys_rst) ##1 !pullup_wr[0] [*2] |-> pullup_on[WIDTH-1:0] == $past(bus_wdata, 2))
      else $error("port 1 pull-ups do not follow written bits");

   a_dir_locked_mode1: assert property (@(posedge sys_clk) disable iff (sys_rst)
      mode_reg == OP_MODE_SINGLE |-> port1_oe == `RST_DIRECTION_MODE1)
      else $error("direction moved while locked in mode 1");

   a_dir_reset_value: assert property (@(posedge sys_clk)
      $fell(sys_rst) |-> port1_oe == ((mode_reg == OP_MODE_SINGLE) ? `RST_DIRECTION_MODE1 : `RST_DIRECTION_MODE23))
      else $error("direction reset value wrong for mode");

   a_dir_write_takes: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dir_wr && mode_reg == OP_MODE_EXPANDED) |=> port1_oe == $past(bus_wdata))
      else $error("direction write lost in modes 2 and 3");

   a_dir_read_hidden: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_rd && addr_hit(bus_addr, `ADDR_PORT1_DIRECTION)) |=> bus_rdata == `READ_WRITE_ONLY)
      else $error("write-only direction byte leaked on read");

   a_data_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
      data_wr ##1 (bus_rd && addr_hit(bus_addr, `ADDR_PORT1_OUTPUT_VALUE) && !data_wr)
      |=> bus_rdata == $past(bus_wdata, 2))
      else $error("data byte read back differs from write");

   a_pin_drive_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
      data_wr |=> port1_out == $past(bus_wdata) && port1_oe == $past(port1_oe) || $past(dir_wr))
      else $error("output pins not driven from data byte");

   a_idle_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$past(bus_rd) |-> bus_rdata == `READ_UNMAPPED)
      else $error("read data stood beyond its cycle");

   // ==========================================================
   // Cover points
   c_mode1_dir_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
      dir_wr && mode_reg == OP_MODE_SINGLE);
   c_mode23_dir_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
      dir_wr && mode_reg == OP_MODE_EXPANDED);
   c_port3_pullup_on: cover property (@(posedge sys_clk) disable iff (sys_rst)
      pullup_wr[2] ##1 pullup_on[3*WIDTH-1:2*WIDTH] != '0);
   c_back_to_back: cover property (@(posedge sys_clk) disable iff (sys_rst)
      data_wr ##1 bus_rd);
endmodule // port_pullup_direction_regs

/* src/port_regs_cfg.svh */
`ifndef PORT_REGS_CFG_SVH
`define PORT_REGS_CFG_SVH

// ==========================================================
// Register addresses
`define ADDR_PORT1_PULLUP_ENABLE 16'hFFAC
`define ADDR_PORT2_PULLUP_ENABLE 16'hFFAD
`define ADDR_PORT3_PULLUP_ENABLE 16'hFFAE
`define ADDR_PORT1_DIRECTION 16'hFFB0
`define ADDR_PORT1_OUTPUT_VALUE 16'hFFB2

// ==========================================================
// Reset values and widths
`define PORT_WIDTH 8
`define ADDR_WIDTH 16
`define PULLUP_PORT_COUNT 3
`define RST_PULLUP 8'h00
`define RST_OUTPUT_VALUE 8'h00
`define RST_DIRECTION_MODE1 8'hFF
`define RST_DIRECTION_MODE23 8'h00
`define READ_WRITE_ONLY 8'hFF
`define READ_UNMAPPED 8'h00

// ==========================================================
// Operating mode pin codes
`define MODE_CODE_1 2'h1

`endif

/* src/port_regs_pkg.sv */
package port_regs_pkg;
   // One port byte
   typedef logic [7:0] port_byte_t;
   // Bus address
   typedef logic [15:0] bus_addr_t;
   // Operating mode as seen by the direction logic
   typedef enum logic {OP_MODE_SINGLE, OP_MODE_EXPANDED} op_mode_t;
endpackage

/* src/port_byte_reg.sv */
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

// One 8-bit port register with a reset value chosen at run time and
// an optional forced value that overrides software writes.
module port_byte_reg #(
   parameter int WIDTH = `PORT_WIDTH
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] rst_value,
   input wire logic force_en,
   input wire logic [WIDTH-1:0] force_value,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] value
);
   // ==========================================================
   // Elaboration check
   if (WIDTH < 1) begin : g_bad_width
      $error("port_byte_reg: WIDTH must be at least 1");
   end

   // ==========================================================
   // Storage
   logic [WIDTH-1:0] value_reg; // Held byte
   logic [WIDTH-1:0] value_next; // Next byte

   // Force beats write so a locked register never moves
   always_comb begin
      value_next = value_reg;
      if (force_en) begin
         value_next = force_value;
      end else if (wr_en) begin
         value_next = wr_data;
      end
   end

   // Plain register, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         value_reg <= rst_value;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;
endmodule // port_byte_reg

/* tb/tb_port_pullup_direction_regs.sv */
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

module tb_port_pullup_direction_regs;
   import port_regs_pkg::*;
   // ==========================================
   // Stimulus and observed signals
   logic sys_clk = 1'b0; // Bus clock
   logic sys_rst = 1'b1; // Held from time zero
   logic [1:0] mode_pins = 2'h2; // Start in an expanded mode
   bus_addr_t bus_addr = 16'h0000;
   port_byte_t bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   port_byte_t bus_rdata;
   logic [23:0] pullup_on; // Ports 3..1, high byte is port 3
   logic [7:0] port1_out;
   logic [7:0] port1_oe;
   int n_fail = 0; // Mismatches seen
   int check_count = 0; // Comparisons made

   port_pullup_direction_regs u_dut (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .mode_pins(mode_pins),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_rdata(bus_rdata),
      .pullup_on(pullup_on),
      .port1_out(port1_out),
      .port1_oe(port1_oe)
   );

   // ==========================================
   // Clock, 50 ns period
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   // ==========================================
   // Helpers
   // Verdict and end of run, the single exit point
   task automatic stop_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never matches
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Reset with mode held; three edges cover the sync flops and latch
   task automatic do_reset(input logic [1:0] m);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      mode_pins <= m;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
   endtask

   // Raise a write strobe; consecutive calls give back-to-back writes
   task automatic wr(input bus_addr_t a, input port_byte_t d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_rd <= 1'b0;
      bus_addr <= a;
      bus_wdata <= d;
   endtask

   // Drop strobes, then look once the taking edge has landed
   task automatic idle();
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      @(negedge sys_clk);
   endtask

   // One-cycle read, data checked in the following cycle only
   task automatic rd(input bus_addr_t a, input port_byte_t exp, input string what);
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      @(negedge sys_clk);
      chk({16'h0000, bus_rdata}, {16'h0000, exp}, what);
   endtask

   // ==========================================
   // Watchdog; the whole run needs under 60 cycles
   initial begin
      #(50 * 3000);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   // ==========================================
   // Tests
   initial begin
      do_reset(2'h2);
      // Expanded mode: everything starts cleared
      chk(pullup_on, 24'h000000, "pullups after reset");
      chk({16'h0000, port1_oe}, 24'h000000, "direction reset mode 2");
      chk({16'h0000, port1_out}, 24'h000000, "data reset");
      rd(`ADDR_PORT1_PULLUP_ENABLE, 8'h00, "read pullup 1");
      rd(`ADDR_PORT2_PULLUP_ENABLE, 8'h00, "read pullup 2");
      rd(`ADDR_PORT3_PULLUP_ENABLE, 8'h00, "read pullup 3");
      rd(`ADDR_PORT1_OUTPUT_VALUE, 8'h00, "read data reset");
      // Back-to-back pull-up writes, each byte reaches only its own port
      wr(`ADDR_PORT1_PULLUP_ENABLE, 8'h01);
      wr(`ADDR_PORT2_PULLUP_ENABLE, 8'h80);
      wr(`ADDR_PORT3_PULLUP_ENABLE, 8'hA5);
      idle();
      chk(pullup_on, 24'hA58001, "pullup pins");
      rd(`ADDR_PORT1_PULLUP_ENABLE, 8'h01, "readback pullup 1");
      rd(`ADDR_PORT2_PULLUP_ENABLE, 8'h80, "readback pullup 2");
      rd(`ADDR_PORT3_PULLUP_ENABLE, 8'hA5, "readback pullup 3");
      // Read data lasts one cycle only
      @(negedge sys_clk);
      chk({16'h0000, bus_rdata}, 24'h000000, "read data held too long");
      // Unmapped places: write ignored, read gives zero
      wr(16'hFFAF, 8'hFF);
      idle();
      chk(pullup_on, 24'hA58001, "unmapped write leaked");
      rd(16'hFFAF, 8'h00, "unmapped read");
      rd(16'hFFB1, 8'h00, "gap read");
      // Clearing a pull-up bit switches it off
      wr(`ADDR_PORT3_PULLUP_ENABLE, 8'h24);
      idle();
      chk(pullup_on, 24'h248001, "pullup cleared");
      // Direction writable but not readable in this mode
      wr(`ADDR_PORT1_DIRECTION, 8'hA5);
      wr(`ADDR_PORT1_OUTPUT_VALUE, 8'h3C);
      // Read straight after the data write, no gap
      rd(`ADDR_PORT1_OUTPUT_VALUE, 8'h3C, "data readback");
      chk({16'h0000, port1_oe}, 24'h0000A5, "direction write");
      chk({16'h0000, port1_out}, 24'h00003C, "data write");
      rd(`ADDR_PORT1_DIRECTION, 8'hFF, "direction read");
      wr(`ADDR_PORT1_DIRECTION, 8'h5A);
      idle();
      chk({16'h0000, port1_oe}, 24'h00005A, "direction rewrite");
      // Single-chip mode: all outputs, locked against writes
      do_reset(`MODE_CODE_1);
      chk({16'h0000, port1_oe}, 24'h0000FF, "direction reset mode 1");
      chk(pullup_on, 24'h000000, "pullups second reset");
      chk({16'h0000, port1_out}, 24'h000000, "data second reset");
      wr(`ADDR_PORT1_DIRECTION, 8'h00);
      wr(`ADDR_PORT1_OUTPUT_VALUE, 8'hC3);
      idle();
      chk({16'h0000, port1_oe}, 24'h0000FF, "locked direction changed");
      chk({16'h0000, port1_out}, 24'h0000C3, "data in mode 1");
      // Mode pins moved outside reset must not matter
      // Pins change on a rising edge like every other input
      @(posedge sys_clk);
      mode_pins <= 2'h3;
      repeat (4) @(posedge sys_clk);
      wr(`ADDR_PORT1_DIRECTION, 8'h0F);
      idle();
      chk({16'h0000, port1_oe}, 24'h0000FF, "mode change outside reset");
      // Mode 3 behaves like mode 2: cleared and writable
      do_reset(2'h3);
      chk({16'h0000, port1_oe}, 24'h000000, "direction reset mode 3");
      chk(pullup_on, 24'h000000, "pullups third reset");
      wr(`ADDR_PORT1_DIRECTION, 8'hC3);
      idle();
      chk({16'h0000, port1_oe}, 24'h0000C3, "direction write mode 3");
      stop_test();
   end
endmodule // tb_port_pullup_direction_regs
